// ### design/startup_circuit_fsm.sv
// The implementer's own choices: the placing of the registers and the AXI4-Lite register port.
`timescale 1ns/1ps
`include "startup_regs.svh"
module startup_circuit_fsm #(
  parameter longint unsigned TICKS_PER_MIN =
    64'(`SU_CLK_HZ) * 64'(`SU_SEC_PER_MIN)
) (
  input  wire logic        clk,
  input  wire logic        sys_rst,
  input  wire logic [7:0]  s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  input  wire logic [7:0]  s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  input  wire logic [15:0] pid_output,
  output logic [15:0]      limited_output,
  output logic [15:0]      min_cycle_time,
  output startup_pkg::startup_state_e state_out
);
  import startup_pkg::*;

  // Registers written by software, then the state and the tuning flags.
  logic [2:0]  ctrl_r;
  logic [15:0] lim_r, setpt_r, hold_r, pv_r, wsp_r, cyc_r;
  startup_state_e state_r, state_nxt;
  logic        tune_lim_r, tune_d_r;

  // Write channel: take address and data in either order.
  logic        aw_have_r, w_have_r;
  logic [7:0]  aw_r;
  logic [31:0] wd_r;
  logic [3:0]  ws_r;
  wire aw_take = s_axi_awvalid && s_axi_awready;
  wire w_take  = s_axi_wvalid && s_axi_wready;
  wire wr_go   = aw_have_r && w_have_r && !s_axi_bvalid;
  wire [15:0] wlo = {ws_r[1] ? wd_r[15:8] : 8'h00,
                     ws_r[0] ? wd_r[7:0]  : 8'h00};
  wire wr_low = ws_r[0] || ws_r[1];
  wire wr_ok  = aw_r[7:5] == 3'h0 && aw_r[1:0] == 2'h0 &&
                aw_r != `SU_STAT_OFS;

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      aw_have_r     <= 1'b0;
      w_have_r      <= 1'b0;
      aw_r          <= 8'h00;
      wd_r          <= 32'h0;
      ws_r          <= 4'h0;
      s_axi_awready <= 1'b0;
      s_axi_wready  <= 1'b0;
      s_axi_bvalid  <= 1'b0;
      s_axi_bresp   <= 2'h0;
    end else begin
      s_axi_awready <= !aw_have_r && !aw_take;
      s_axi_wready  <= !w_have_r && !w_take;
      if (aw_take) begin
        aw_have_r <= 1'b1;
        aw_r      <= s_axi_awaddr;
      end
      if (w_take) begin
        w_have_r <= 1'b1;
        wd_r     <= s_axi_wdata;
        ws_r     <= s_axi_wstrb;
      end
      if (wr_go) begin
        aw_have_r    <= 1'b0;
        w_have_r     <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= wr_ok ? 2'h0 : 2'h2;
      end else if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  wire do_wr = wr_go && wr_ok && wr_low;
  wire [15:0] hold_in = (wlo > `SU_HOLD_MAX) ? `SU_HOLD_MAX : wlo;

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      ctrl_r  <= 3'h0;
      lim_r   <= `SU_LIMIT_RST;
      setpt_r <= `SU_SETPT_RST;
      hold_r  <= `SU_HOLD_RST;
      pv_r    <= 16'h0;
      wsp_r   <= 16'h0;
      cyc_r   <= `SU_CYC_RST;
    end else if (do_wr) begin
      unique case (aw_r)
        `SU_CTRL_OFS:  ctrl_r  <= wlo[2:0];
        `SU_LIMIT_OFS: lim_r   <= wlo;
        `SU_SETPT_OFS: setpt_r <= wlo;
        `SU_HOLD_OFS:  hold_r  <= hold_in;
        `SU_PV_OFS:    pv_r    <= wlo;
        `SU_WSP_OFS:   wsp_r   <= wlo;
        `SU_CYC_OFS:   cyc_r   <= wlo;
        default:       ctrl_r  <= ctrl_r;
      endcase
    end
  end

  // Read channel: one-cycle decode, data held until rready.
  logic [31:0] rd_mux;
  wire rd_ok = s_axi_araddr[7:5] == 3'h0 && s_axi_araddr[1:0] == 2'h0;
  always_comb begin
    unique case (s_axi_araddr)
      `SU_CTRL_OFS:  rd_mux = {29'h0, ctrl_r};
      `SU_LIMIT_OFS: rd_mux = {16'h0, lim_r};
      `SU_SETPT_OFS: rd_mux = {16'h0, setpt_r};
      `SU_HOLD_OFS:  rd_mux = {16'h0, hold_r};
      `SU_PV_OFS:    rd_mux = {16'h0, pv_r};
      `SU_WSP_OFS:   rd_mux = {16'h0, wsp_r};
      `SU_STAT_OFS:  rd_mux = {29'h0, tune_lim_r, 2'(state_r)};
      `SU_CYC_OFS:   rd_mux = {16'h0, cyc_r};
      default:       rd_mux = 32'h0;
    endcase
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= 32'h0;
      s_axi_rresp   <= 2'h0;
    end else begin
      s_axi_arready <= !s_axi_rvalid && !(s_axi_arvalid && s_axi_arready);
      if (s_axi_arvalid && s_axi_arready) begin
        s_axi_rvalid <= 1'b1;
        s_axi_rdata  <= rd_mux;
        s_axi_rresp  <= rd_ok ? 2'h0 : 2'h2;
      end else if (s_axi_rvalid && s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
    end
  end

  // Control quantities; temperatures are signed whole kelvin.
  temp_t pv, wa, w, tgt;
  assign pv = temp_t'(pv_r);
  assign wa = temp_t'(setpt_r);
  assign w  = temp_t'(wsp_r);
  assign tgt = (w < wa) ? w : wa;
  wire enabled  = ctrl_r[`SU_CTRL_EN_BIT] && ctrl_r[`SU_CTRL_AUTO_BIT];
  wire tune_req = ctrl_r[`SU_CTRL_TUNE_BIT];
  wire tune_end = tune_d_r && !tune_req;
  wire wa_below = wa < w;
  wire near_tgt = pv > tgt - temp_t'(`SU_BAND_1K) && pv <= tgt;
  // The deviation is taken against the active start-up target, which is
  // what the loop regulates to; against the working set-point the hold exit
  // after tuning could never be reached.
  wire dev_small = (pv > tgt - temp_t'(`SU_BAND_1K)) &&
                   (pv < tgt + temp_t'(`SU_BAND_1K));
  wire big_drop = pv < tgt - temp_t'(`SU_DROP_40K);
  wire hold_done;

  startup_min_timer #(
    .TICKS_PER_MIN (TICKS_PER_MIN)
  ) u_timer (
    .clk     (clk),
    .sys_rst (sys_rst),
    .run     (state_r == startup_hold_state),
    .limit   (hold_r),
    .expired (hold_done)
  );

  // Power-on enters limited state once when started below the start-up set-point, itself below the working set-point.
  logic armed_r;
  always_comb begin
    state_nxt = state_r;
    if (!enabled) begin
      state_nxt = startup_idle_state;
    end else if (tune_req && state_r != startup_tuning_state) begin
      state_nxt = startup_tuning_state;
    end else begin
      unique case (state_r)
        startup_idle_state: begin
          if (armed_r && pv < wa && wa_below)
            state_nxt = startup_limited_output_state;
          else if (big_drop)
            state_nxt = startup_limited_output_state;
        end
        startup_limited_output_state: begin
          if (near_tgt && wa_below)
            state_nxt = startup_hold_state;
          else if (near_tgt)
            state_nxt = startup_idle_state;
        end
        startup_hold_state: begin
          if (big_drop)
            state_nxt = startup_limited_output_state;
          else if (!wa_below)
            state_nxt = startup_idle_state;
          else if (hold_done)
            state_nxt = startup_idle_state;
        end
        startup_tuning_state: begin
          if (!tune_end)
            state_nxt = state_r;
          else if (pv > tgt)
            state_nxt = startup_idle_state;
          else if (dev_small && wa_below)
            state_nxt = startup_hold_state;
          else if (dev_small)
            state_nxt = startup_idle_state;
          else
            state_nxt = startup_limited_output_state;
        end
      endcase
    end
  end

  wire limiting = state_r == startup_limited_output_state ||
                  (state_r == startup_tuning_state && tune_lim_r);
  wire [15:0] quarter = {2'b00, cyc_r[15:2]};

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      state_r        <= startup_idle_state;
      armed_r        <= 1'b1;
      tune_d_r       <= 1'b0;
      tune_lim_r     <= 1'b0;
      limited_output <= 16'h0;
      min_cycle_time <= 16'h0;
      state_out      <= startup_idle_state;
    end else begin
      state_r   <= state_nxt;
      state_out <= state_nxt;
      tune_d_r  <= tune_req && enabled;
      if (!enabled)
        armed_r <= 1'b1;
      else if (state_r == startup_idle_state)
        armed_r <= 1'b0;
      if (state_nxt == startup_tuning_state &&
          state_r != startup_tuning_state)
        tune_lim_r <= state_r == startup_limited_output_state;
      limited_output <= (limiting && pid_output > lim_r) ?
                        lim_r : pid_output;
      if (state_nxt == startup_limited_output_state)
        min_cycle_time <= (quarter > `SU_MIN_CYC_TICKS) ?
                          quarter : 16'(`SU_MIN_CYC_TICKS);
      else
        min_cycle_time <= cyc_r;
    end
  end

  chk_reset_idle: assert property (
    @(posedge clk) sys_rst |=> state_r == startup_idle_state)
    else $error("state not idle after reset");
  chk_disable_idle: assert property (
    @(posedge clk) disable iff (sys_rst)
    !enabled |=> state_r == startup_idle_state)
    else $error("disabled circuit not idle");
  chk_cap_output: assert property (
    @(posedge clk) disable iff (sys_rst)
    limiting |=> limited_output <= $past(lim_r))
    else $error("output cap not applied");
  chk_low_passes: assert property (
    @(posedge clk) disable iff (sys_rst)
    pid_output <= lim_r |=> limited_output == $past(pid_output))
    else $error("low output altered");
  chk_quarter_cyc: assert property (
    @(posedge clk) disable iff (sys_rst)
    state_r == startup_limited_output_state |->
    min_cycle_time >= 16'(`SU_MIN_CYC_TICKS))
    else $error("cycle time below floor");
  chk_hold_entry: assert property (
    @(posedge clk) disable iff (sys_rst)
    enabled && !tune_req && state_r == startup_limited_output_state &&
    near_tgt && wa_below |=> state_r == startup_hold_state)
    else $error("hold not entered");
  chk_hold_cancel: assert property (
    @(posedge clk) disable iff (sys_rst)
    enabled && !tune_req && state_r == startup_hold_state && !big_drop &&
    !wa_below |=> state_r == startup_idle_state)
    else $error("hold not cancelled");
  chk_restart_drop: assert property (
    @(posedge clk) disable iff (sys_rst)
    enabled && !tune_req && state_r != startup_tuning_state && big_drop
    |=> state_r == startup_limited_output_state)
    else $error("no restart on drop");
  chk_tune_hold: assert property (
    @(posedge clk) disable iff (sys_rst)
    enabled && state_r == startup_tuning_state && tune_end &&
    pv <= tgt && dev_small && wa_below |=> state_r == startup_hold_state)
    else $error("hold not entered after tuning");
  cov_tune_limited: cover property (@(posedge clk)
    state_r == startup_tuning_state && tune_lim_r);
  cov_hold: cover property (@(posedge clk)
    state_r == startup_hold_state ##1 state_r == startup_idle_state);
  cov_tune: cover property (@(posedge clk)
    state_r == startup_tuning_state ##1 state_r == startup_hold_state);
  cov_restart: cover property (@(posedge clk)
    state_r == startup_idle_state ##1
    state_r == startup_limited_output_state);
endmodule : startup_circuit_fsm

// ### pkg/startup_regs.svh
`ifndef STARTUP_REGS_SVH
`define STARTUP_REGS_SVH
`define SU_CTRL_OFS        8'h00
`define SU_LIMIT_OFS       8'h04
`define SU_SETPT_OFS       8'h08
`define SU_HOLD_OFS        8'h0c
`define SU_PV_OFS          8'h10
`define SU_WSP_OFS         8'h14
`define SU_STAT_OFS        8'h18
`define SU_CYC_OFS         8'h1c
`define SU_CTRL_EN_BIT     0
`define SU_CTRL_AUTO_BIT   1
`define SU_CTRL_TUNE_BIT   2
`define SU_LIMIT_RST       16'h0005
`define SU_SETPT_RST       16'h005f
`define SU_HOLD_RST        16'h000a
`define SU_HOLD_MAX        16'h270f
`define SU_CYC_RST         16'h0010
`define SU_BAND_1K         16'h0001
`define SU_DROP_40K        16'h0028
`define SU_MIN_CYC_TICKS   16'h0007
`define SU_SEC_PER_MIN     60
`define SU_CLK_HZ          125000000
`endif

// ### pkg/startup_pkg.sv
package startup_pkg;
  typedef enum logic [1:0] {
    startup_idle_state,
    startup_limited_output_state,
    startup_hold_state,
    startup_tuning_state
  } startup_state_e;
  typedef logic signed [15:0] temp_t;
endpackage : startup_pkg

// ### design/startup_min_timer.sv
`timescale 1ns/1ps
`include "startup_regs.svh"
// Counts hold minutes; one tick pulse per minute of clock cycles.
// A minute of scan clock does not fit 32 bits, hence the wide parameter.
module startup_min_timer #(
  parameter longint unsigned TICKS_PER_MIN =
    64'(`SU_CLK_HZ) * 64'(`SU_SEC_PER_MIN)
) (
  input  wire logic        clk,
  input  wire logic        sys_rst,
  input  wire logic        run,
  input  wire logic [15:0] limit,
  output logic             expired
);
  logic [39:0] pre_r;
  logic [15:0] min_r;
  wire         tick = (pre_r == 40'(TICKS_PER_MIN - 1));
  always_ff @(posedge clk) begin
    if (sys_rst || !run) begin
      pre_r <= 40'h0;
      min_r <= 16'h0;
    end else begin
      pre_r <= tick ? 40'h0 : pre_r + 40'h1;
      if (tick && min_r != 16'hffff)
        min_r <= min_r + 16'h1;
    end
  end
  assign expired = run && (min_r >= limit);
endmodule : startup_min_timer

// ### tb/pid_loop_model.sv
`timescale 1ns/1ps
// Stands in for the PID stage: presents the requested output one cycle later,
// as a registered controller output would.
module pid_loop_model (
  input  wire logic        clk,
  input  wire logic        sys_rst,
  input  wire logic [15:0] demand,
  output logic [15:0]      pid_output
);
  always_ff @(posedge clk) begin
    if (sys_rst) pid_output <= 16'h0000;
    else pid_output <= demand;
  end
endmodule : pid_loop_model

// ### tb/startup_circuit_fsm_tb.sv
`timescale 1ns/1ps
`include "startup_regs.svh"
module startup_circuit_fsm_tb;
  import startup_pkg::*;
  logic        clk, sys_rst, awvalid, wvalid, bready, arvalid, rready;
  logic        awready, wready, bvalid, arready, rvalid;
  logic [7:0]  awaddr, araddr;
  logic [31:0] wdata, rdata, rd;
  logic [3:0]  wstrb;
  logic [1:0]  bresp, rresp, resp;
  logic [15:0] demand, pid_output, limited_output, min_cycle_time;
  startup_state_e state_out;
  int n_mismatch = 0;
  int tests_run = 0;

  pid_loop_model partner (.clk(clk), .sys_rst(sys_rst), .demand(demand),
    .pid_output(pid_output));
  startup_circuit_fsm #(.TICKS_PER_MIN(10)) DUT (.clk(clk), .sys_rst(sys_rst),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid),
    .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
    .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
    .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
    .s_axi_rvalid(rvalid), .s_axi_rready(rready), .pid_output(pid_output),
    .limited_output(limited_output), .min_cycle_time(min_cycle_time),
    .state_out(state_out));

  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end

  task automatic final_report;
    if (n_mismatch == 0 && tests_run > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask : final_report

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("CHECK FAILED %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : check

  // Write address and data are offered together and dropped once taken.
  task automatic axi_wr(input logic [7:0] a, input logic [31:0] d);
    int n;
    @(posedge clk);
    awaddr <= a; wdata <= d; wstrb <= 4'hf;
    awvalid <= 1'b1; wvalid <= 1'b1; bready <= 1'b1;
    for (n = 0; n < 1000; n++) begin
      @(posedge clk);
      if (awvalid && awready) awvalid <= 1'b0;
      if (wvalid && wready) wvalid <= 1'b0;
      if (bvalid && bready) break;
    end
    if (n == 1000) n_mismatch++;
    resp = bresp;
    bready <= 1'b0;
  endtask : axi_wr

  task automatic axi_rd(input logic [7:0] a);
    int n;
    @(posedge clk);
    araddr <= a; arvalid <= 1'b1; rready <= 1'b1;
    for (n = 0; n < 1000; n++) begin
      @(posedge clk);
      if (arvalid && arready) arvalid <= 1'b0;
      if (rvalid && rready) break;
    end
    if (n == 1000) n_mismatch++;
    rd = rdata; resp = rresp;
    rready <= 1'b0;
  endtask : axi_rd

  // Polls under a bound so a slow but correct transition is not flagged.
  task automatic wait_state(input startup_state_e s);
    int n;
    for (n = 0; n < 200 && state_out !== s; n++) @(posedge clk);
    repeat (2) @(posedge clk);
    check(32'(state_out), 32'(s));
  endtask : wait_state

  task automatic pv(input logic [15:0] v);
    axi_wr(`SU_PV_OFS, {16'h0000, v});
  endtask : pv

  initial begin
    sys_rst = 1'b1; awvalid = 1'b0; wvalid = 1'b0; bready = 1'b0;
    arvalid = 1'b0; rready = 1'b0; awaddr = 8'h00; araddr = 8'h00;
    wdata = 32'h0; wstrb = 4'h0; demand = 16'h0032;
    repeat (8) @(posedge clk);
    sys_rst <= 1'b0;
    check(32'(state_out), 32'(startup_idle_state));
    axi_rd(`SU_STAT_OFS); check(rd, 32'h0);
    axi_rd(`SU_LIMIT_OFS); check(rd, 32'h5);
    check(32'(resp), 32'h0);
    axi_rd(`SU_SETPT_OFS); check(rd, 32'h5f);
    axi_rd(`SU_HOLD_OFS); check(rd, 32'ha);
    axi_rd(`SU_CYC_OFS); check(rd, 32'h10);
    axi_rd(8'h20); check(rd, 32'h0);
    check(32'(resp), 32'h2);
    axi_wr(`SU_STAT_OFS, 32'h3); check(32'(resp), 32'h2);
    axi_wr(`SU_HOLD_OFS, 32'h2710);
    axi_rd(`SU_HOLD_OFS); check(rd, 32'h270f);
    axi_wr(`SU_HOLD_OFS, 32'h1);
    check(32'(resp), 32'h0);
    pv(16'h0014);
    axi_wr(`SU_WSP_OFS, 32'hc8);
    axi_wr(`SU_CYC_OFS, 32'h40);
    repeat (3) @(posedge clk);
    check(32'(min_cycle_time), 32'h40);
    axi_wr(`SU_CTRL_OFS, 32'h3);
    wait_state(startup_limited_output_state);
    check(32'(limited_output), 32'h5);
    check(32'(min_cycle_time), 32'h10);
    demand <= 16'h0003;
    repeat (4) @(posedge clk);
    check(32'(limited_output), 32'h3);
    demand <= 16'h0032;
    axi_wr(`SU_CYC_OFS, 32'h10);
    repeat (3) @(posedge clk);
    check(32'(min_cycle_time), 32'h7);
    pv(16'h005f); wait_state(startup_hold_state);
    pv(16'h0032); wait_state(startup_limited_output_state);
    pv(16'h005f); wait_state(startup_hold_state);
    wait_state(startup_idle_state);
    pv(16'h0032); wait_state(startup_limited_output_state);
    pv(16'h005f); wait_state(startup_hold_state);
    axi_wr(`SU_WSP_OFS, 32'h5a); wait_state(startup_idle_state);
    pv(16'h0028); wait_state(startup_limited_output_state);
    pv(16'h005a); wait_state(startup_idle_state);
    pv(16'h0028); wait_state(startup_limited_output_state);
    axi_wr(`SU_CTRL_OFS, 32'h7); wait_state(startup_tuning_state);
    axi_rd(`SU_STAT_OFS); check(rd, 32'h7);
    check(32'(limited_output), 32'h5);
    pv(16'h0064);
    axi_wr(`SU_CTRL_OFS, 32'h3); wait_state(startup_idle_state);
    axi_wr(`SU_WSP_OFS, 32'hc8);
    pv(16'h005f);
    axi_wr(`SU_CTRL_OFS, 32'h7); wait_state(startup_tuning_state);
    axi_rd(`SU_STAT_OFS); check(rd, 32'h3);
    check(32'(limited_output), 32'h32);
    axi_wr(`SU_CTRL_OFS, 32'h3); wait_state(startup_hold_state);
    axi_wr(`SU_WSP_OFS, 32'h5a); wait_state(startup_idle_state);
    pv(16'h005a);
    axi_wr(`SU_CTRL_OFS, 32'h7); wait_state(startup_tuning_state);
    axi_wr(`SU_CTRL_OFS, 32'h3); wait_state(startup_idle_state);
    pv(16'h0028); wait_state(startup_limited_output_state);
    axi_wr(`SU_CTRL_OFS, 32'h1); wait_state(startup_idle_state);
    axi_wr(`SU_CTRL_OFS, 32'h2);
    repeat (20) @(posedge clk);
    check(32'(state_out), 32'(startup_idle_state));
    final_report();
  end

  initial begin
    repeat (20000) @(posedge clk);
    n_mismatch++;
    final_report();
  end
endmodule : startup_circuit_fsm_tb
